// ---- rtl/wwd_top.sv ----
// Window watchdog with mode control gating it.
// Assumes pins are asynchronous to clk_i; host keeps its own timing.
//
// Functional notes
// - Reset output low forces fail-safe mode.
// - Enable falling edge with transmit high enters silent mode.
// - Transmit path disabled while silent.
// - Undervoltage in silent mode drives reset low, enters fail-safe.
// - Trigger on negative edge only; pulses of 200 ns or less rejected.
// - Intervals counted in oscillator periods set by the timing resistor.
// - Watchdog stopped in silent and sleep modes.
// - After wake, lead time starts at receive falling edge.
// - Lead 7895, closed 1053, open 1105 oscillator periods.
// - Each watchdog reset pulse lasts 4 ms regardless of resistor.
// - Power-up holds reset low 4 ms, then lead time starts.
// - Trigger during lead time starts closed window at once.
// - Lead time expiry gives a reset pulse, then lead time again.
// - Trigger in open window starts a new closed window.
// - Open window expiry pulls reset low.
// - Trigger in closed window drives reset low at once.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_regs.svh"

module wwd_top
	import wwd_pkg::*;
#(
	parameter int unsigned     LEAD_OSC   = `WWD_LEAD_OSC,
	parameter int unsigned     CLOSED_OSC = `WWD_CLOSED_OSC,
	parameter int unsigned     OPEN_OSC   = `WWD_OPEN_OSC,
	parameter int unsigned     NRES_CYC   = `WWD_NRES_CYC,
	parameter int unsigned     DIV_W      = 16,
	parameter int unsigned     NRES_W     = 16
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire wwd_pins_t        pins_i,
	input  wire logic [DIV_W-1:0] timing_resistor_i,
	input  wire logic             txd_data_i,
	output logic                  nres_n_o,
	output logic                  bus_tx_o,
	output logic                  bus_tx_en_o,
	output wwd_mode_t             mode_o,
	output wwd_state_t            wd_state_o
);

	localparam logic [`WWD_CNT_W-1:0] LEAD_C   = `WWD_CNT_W'(LEAD_OSC);
	localparam logic [`WWD_CNT_W-1:0] CLOSED_C = `WWD_CNT_W'(CLOSED_OSC);
	localparam logic [`WWD_CNT_W-1:0] OPEN_C   = `WWD_CNT_W'(OPEN_OSC);
	localparam logic [NRES_W-1:0]     NRES_C   = NRES_W'(NRES_CYC);
	localparam logic [2:0]            TMIN_C   = 3'(`WWD_TRIG_MIN_CYC);

	// ************************************************
	// Synchronisers
	// ************************************************
	wwd_pins_t pins_s1_q;
	wwd_pins_t pins_s2_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_s1_q <= 6'b11_1_0_0_0 | 6'b10_0_0_0_0;
			pins_s2_q <= 6'b11_1_0_0_0 | 6'b10_0_0_0_0;
		end else begin
			pins_s1_q <= pins_i;
			pins_s2_q <= pins_s1_q;
		end
	end

	logic en_prev_q;
	logic rx_prev_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_prev_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			en_prev_q <= pins_s2_q.enable;
			rx_prev_q <= pins_s2_q.receive;
		end
	end

	logic en_fall;
	logic rx_fall;
	assign en_fall = en_prev_q & ~pins_s2_q.enable;
	assign rx_fall = rx_prev_q & ~pins_s2_q.receive;

	// ************************************************
	// Trigger qualification
	// ************************************************
	// Low time counted in system cycles; a trigger fires once it exceeds the minimum
	logic [2:0] low_cnt_q;
	logic       trig_fired_q;
	logic       trig_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_cnt_q    <= 3'h0;
			trig_fired_q <= 1'b0;
			trig_q       <= 1'b0;
		end else if (pins_s2_q.wd_trigger_n) begin
			low_cnt_q    <= 3'h0;
			trig_fired_q <= 1'b0;
			trig_q       <= 1'b0;
		end else if (low_cnt_q >= TMIN_C && !trig_fired_q) begin
			trig_fired_q <= 1'b1;
			trig_q       <= 1'b1;
		end else begin
			// Third low sample fires, so 300 ns passes and 200 ns does not
			if (low_cnt_q < TMIN_C) begin
				low_cnt_q <= low_cnt_q + 3'h1;
			end
			trig_q <= 1'b0;
		end
	end

	// ************************************************
	// Mode control
	// ************************************************
	wwd_mode_t mode_q;
	logic      wd_run;
	logic      wd_fault;
	logic      wake_q;

	// Sleep and wake are driven by pins; only the digital gating lives here
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_q <= WWD_MODE_NORMAL;
			wake_q <= 1'b0;
		end else begin
			wake_q <= 1'b0;
			case (mode_q)
				WWD_MODE_NORMAL: begin
					if (wd_fault || !nres_n_o) begin
						mode_q <= WWD_MODE_FAILSAFE;
					end else if (en_fall && pins_s2_q.transmit) begin
						mode_q <= WWD_MODE_SILENT;
					end else if (pins_s2_q.sleep_req) begin
						mode_q <= WWD_MODE_SLEEP;
					end
				end
				WWD_MODE_SILENT, WWD_MODE_SLEEP: begin
					if (mode_q == WWD_MODE_SILENT && pins_s2_q.undervoltage) begin
						mode_q <= WWD_MODE_FAILSAFE;
					end else if (rx_fall) begin
						mode_q <= WWD_MODE_NORMAL;
						wake_q <= 1'b1;
					end
				end
				WWD_MODE_FAILSAFE: begin
					if (nres_n_o && pins_s2_q.enable && !pins_s2_q.undervoltage) begin
						mode_q <= WWD_MODE_NORMAL;
					end
				end
				default: mode_q <= WWD_MODE_FAILSAFE;
			endcase
		end
	end

	// Watchdog keeps running in fail-safe so a stuck host keeps getting resets
	assign wd_run = (mode_q == WWD_MODE_NORMAL) || (mode_q == WWD_MODE_FAILSAFE);

	// ************************************************
	// Watchdog oscillator
	// ************************************************
	logic osc_tick;

	wwd_osc_div #(
		.DIV_W (DIV_W)
	) u_osc (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (wd_run),
		.period_i  (timing_resistor_i),
		.tick_o    (osc_tick)
	);

	// ************************************************
	// Window sequencer
	// ************************************************
	wwd_state_t             st_q;
	logic [`WWD_CNT_W-1:0]  win_q;
	logic [NRES_W-1:0]      nres_cnt_q;
	logic                   uv_silent;

	assign uv_silent = (mode_q == WWD_MODE_SILENT) && pins_s2_q.undervoltage;
	assign wd_fault  = wd_run && (
		(st_q == WWD_ST_CLOSED && trig_q) ||
		(st_q != WWD_ST_RESET && st_q != WWD_ST_CLOSED && osc_tick && win_q == `WWD_ONE
			&& !trig_q));

	// Power-up starts in the reset pulse, then lead time
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q       <= WWD_ST_RESET;
			win_q      <= LEAD_C;
			nres_cnt_q <= NRES_C;
		end else if (uv_silent) begin
			st_q       <= WWD_ST_RESET;
			nres_cnt_q <= NRES_C;
		end else if (wake_q) begin
			st_q  <= WWD_ST_LEAD;
			win_q <= LEAD_C;
		end else if (st_q == WWD_ST_RESET) begin
			// Pulse length runs on the system clock, so the resistor cannot stretch it
			if (nres_cnt_q == NRES_W'(1)) begin
				st_q  <= WWD_ST_LEAD;
				win_q <= LEAD_C;
			end else begin
				nres_cnt_q <= nres_cnt_q - NRES_W'(1);
			end
		end else if (wd_run) begin
			case (st_q)
				WWD_ST_LEAD: begin
					if (trig_q) begin
						st_q  <= WWD_ST_CLOSED;
						win_q <= CLOSED_C;
					end else if (osc_tick && win_q == `WWD_ONE) begin
						st_q       <= WWD_ST_RESET;
						nres_cnt_q <= NRES_C;
					end else if (osc_tick) begin
						win_q <= win_q - `WWD_ONE;
					end
				end
				WWD_ST_CLOSED: begin
					if (trig_q) begin
						st_q       <= WWD_ST_RESET;
						nres_cnt_q <= NRES_C;
					end else if (osc_tick && win_q == `WWD_ONE) begin
						st_q  <= WWD_ST_OPEN;
						win_q <= OPEN_C;
					end else if (osc_tick) begin
						win_q <= win_q - `WWD_ONE;
					end
				end
				WWD_ST_OPEN: begin
					if (trig_q) begin
						st_q  <= WWD_ST_CLOSED;
						win_q <= CLOSED_C;
					end else if (osc_tick && win_q == `WWD_ONE) begin
						st_q       <= WWD_ST_RESET;
						nres_cnt_q <= NRES_C;
					end else if (osc_tick) begin
						win_q <= win_q - `WWD_ONE;
					end
				end
				default: begin
					st_q       <= WWD_ST_RESET;
					nres_cnt_q <= NRES_C;
				end
			endcase
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	// Reset output follows the sequencer's next state so a fault shows on the same edge as st_q enters reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nres_n_o    <= 1'b0;
			bus_tx_o    <= 1'b1;
			bus_tx_en_o <= 1'b0;
			mode_o      <= WWD_MODE_NORMAL;
			wd_state_o  <= WWD_ST_RESET;
		end else begin
			nres_n_o    <= !(uv_silent || wd_fault ||
				(st_q == WWD_ST_RESET && !(nres_cnt_q == NRES_W'(1))));
			bus_tx_o    <= txd_data_i;
			bus_tx_en_o <= (mode_q == WWD_MODE_NORMAL);
			mode_o      <= mode_q;
			wd_state_o  <= st_q;
		end
	end

endmodule

`default_nettype wire

// ---- rtl/wwd_regs.svh ----
// Timing and width constants for the window watchdog block.
// Assumes a 10 MHz system clock; included by its bare name.
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

`define WWD_CLK_PERIOD_NS   100
`define WWD_TRIG_MIN_NS     200
`define WWD_TRIG_MIN_CYC    ((`WWD_TRIG_MIN_NS + `WWD_CLK_PERIOD_NS - 1) / `WWD_CLK_PERIOD_NS)
`define WWD_NRES_MS         4
`define WWD_NRES_CYC        ((`WWD_NRES_MS * 1000000) / `WWD_CLK_PERIOD_NS)
`define WWD_LEAD_OSC        7895
`define WWD_CLOSED_OSC      1053
`define WWD_OPEN_OSC        1105
`define WWD_OSC_DIV         196
`define WWD_CNT_W           14
`define WWD_ONE             14'h0001
`define WWD_ZERO            14'h0000

`endif

// ---- rtl/wwd_pkg.sv ----
// Types shared by the window watchdog block.
// Assumes nothing of its surroundings.
package wwd_pkg;

	typedef enum logic [1:0] {
		WWD_MODE_NORMAL   = 2'b00,
		WWD_MODE_SILENT   = 2'b01,
		WWD_MODE_SLEEP    = 2'b10,
		WWD_MODE_FAILSAFE = 2'b11
	} wwd_mode_t;

	typedef enum logic [1:0] {
		WWD_ST_LEAD   = 2'b00,
		WWD_ST_CLOSED = 2'b01,
		WWD_ST_OPEN   = 2'b10,
		WWD_ST_RESET  = 2'b11
	} wwd_state_t;

	typedef struct packed {
		logic wd_trigger_n;
		logic enable;
		logic transmit;
		logic receive;
		logic undervoltage;
		logic sleep_req;
	} wwd_pins_t;

endpackage

// ---- rtl/wwd_osc_div.sv ----
// Watchdog oscillator tick generator.
// Assumes the resistor setting arrives as a period in system cycles.
`timescale 1ns/1ps
`default_nettype none

module wwd_osc_div
	import wwd_pkg::*;
#(
	parameter int unsigned DIV_W = 16
) (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             run_i,
	input  wire logic [DIV_W-1:0] period_i,
	output logic                  tick_o
);

	logic [DIV_W-1:0] cnt_q;

	// Restart on run so the first tick is a full period away
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else if (cnt_q + DIV_W'(1) >= period_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + DIV_W'(1);
			tick_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- verif/wwd_chk.sv ----
// Checker on the window watchdog top ports, bound into wwd_top.
// Assumes one clock and a steady timing_resistor_i.
`timescale 1ns/1ps
`default_nettype none
module wwd_chk
	import wwd_pkg::*;
#(
	parameter int unsigned LEAD_OSC = 16,
	parameter int unsigned OPEN_OSC = 6,
	parameter int unsigned NRES_CYC = 20,
	parameter int unsigned DIV_W    = 16
) (
	input wire logic             clk_i,
	input wire logic             reset_n_i,
	input wire wwd_pins_t        pins_i,
	input wire logic [DIV_W-1:0] timing_resistor_i,
	input wire logic             txd_data_i,
	input wire logic             nres_n_o,
	input wire logic             bus_tx_o,
	input wire logic             bus_tx_en_o,
	input wire wwd_mode_t        mode_o,
	input wire wwd_state_t       wd_state_o
);
	int unsigned lo_q;
	int unsigned st_q;
	wwd_state_t  ps_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Quiet modes restart the age, so a stopped window never looks long
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lo_q <= 0;
			st_q <= 0;
			ps_q <= WWD_ST_RESET;
		end else begin
			lo_q <= nres_n_o ? 0 : lo_q + 1;
			st_q <= (wd_state_o != ps_q || mode_o inside {WWD_MODE_SILENT, WWD_MODE_SLEEP})
				? 1 : st_q + 1;
			ps_q <= wd_state_o;
		end
	end
	a_nres_failsafe:
		assert property (!nres_n_o && mode_o == WWD_MODE_NORMAL
			|-> ##[1:3] mode_o == WWD_MODE_FAILSAFE) else $error("no fail-safe");
	a_silent_txoff:
		assert property (mode_o == WWD_MODE_SILENT && $past(mode_o) == WWD_MODE_SILENT
			|-> !bus_tx_en_o) else $error("tx on in silent");
	a_silent_entry:
		assert property (mode_o == WWD_MODE_NORMAL && $fell(pins_i.enable) && pins_i.transmit
			##1 pins_i.transmit [*3] |-> ##[0:6] mode_o == WWD_MODE_SILENT)
			else $error("silent not entered");
	a_pulse_len:
		assert property ($rose(nres_n_o) |-> lo_q + 1 >= NRES_CYC && lo_q <= NRES_CYC + 3)
			else $error("reset pulse length");
	a_lead_len:
		assert property (wd_state_o == WWD_ST_RESET && ps_q == WWD_ST_LEAD
			&& !pins_i.undervoltage |-> st_q >= (LEAD_OSC - 1) * timing_resistor_i
			&& st_q <= LEAD_OSC * timing_resistor_i + 2) else $error("lead length");
	a_open_len:
		assert property (wd_state_o == WWD_ST_RESET && ps_q == WWD_ST_OPEN
			&& !pins_i.undervoltage |-> st_q >= (OPEN_OSC - 1) * timing_resistor_i
			&& st_q <= OPEN_OSC * timing_resistor_i + 2) else $error("open length");
	a_early_trig:
		assert property (wd_state_o == WWD_ST_CLOSED && ps_q == WWD_ST_CLOSED && st_q < 3
			&& $fell(pins_i.wd_trigger_n) ##1 !pins_i.wd_trigger_n [*2]
			|-> ##[1:8] !nres_n_o) else $error("early trigger kept");
	a_glitch_drop:
		assert property (wd_state_o == WWD_ST_LEAD && ps_q == WWD_ST_LEAD && st_q < 8
			&& $fell(pins_i.wd_trigger_n) ##1 !pins_i.wd_trigger_n ##1 pins_i.wd_trigger_n
			|-> (wd_state_o == WWD_ST_LEAD) [*5]) else $error("glitch taken");
	c_silent: cover property (mode_o == WWD_MODE_SILENT);
	c_early: cover property (ps_q == WWD_ST_CLOSED && wd_state_o == WWD_ST_RESET);
	c_open_ok: cover property (ps_q == WWD_ST_OPEN && wd_state_o == WWD_ST_CLOSED);
endmodule
bind wwd_top wwd_chk #(.LEAD_OSC(LEAD_OSC), .OPEN_OSC(OPEN_OSC), .NRES_CYC(NRES_CYC),
	.DIV_W(DIV_W)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .pins_i(pins_i),
	.timing_resistor_i(timing_resistor_i), .txd_data_i(txd_data_i), .nres_n_o(nres_n_o),
	.bus_tx_o(bus_tx_o), .bus_tx_en_o(bus_tx_en_o), .mode_o(mode_o), .wd_state_o(wd_state_o));
`default_nettype wire

// ---- verif/wwd_host.sv ----
// Host model driving the active-low watchdog trigger.
// Assumes the bench calls fire between clock edges.
`timescale 1ns/1ps
`default_nettype none
module wwd_host (
	input  wire logic clk_i,
	output logic      trig_n_o
);
	initial trig_n_o = 1'b1;
	// Width in sampled cycles; 2 is a deliberate glitch
	task automatic fire(input int len);
		@(posedge clk_i);
		trig_n_o <= 1'b0;
		repeat (len) @(posedge clk_i);
		trig_n_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- verif/window_watchdog_mode_ctrl_test.sv ----
// Self-checking bench for the window watchdog top.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_mode_ctrl_test;
	import wwd_pkg::*;
	logic       clk = 0, rst_n = 0, en = 1, tx = 1, rx = 1, uv = 0, slp = 0, txd = 0;
	logic       trig_n, nres, tx_o, tx_en;
	logic [15:0] rres = 16'h0002;
	wwd_mode_t  mode;
	wwd_state_t st;
	int         n_errors = 0;
	int         check_count = 0;
	always #50 clk = ~clk;
	always @(posedge clk) txd <= ~txd;
	wwd_host i_host (.clk_i(clk), .trig_n_o(trig_n));
	// Short windows keep the run brief; lead 32, closed 16, open 12 cycles
	wwd_top #(.LEAD_OSC(16), .CLOSED_OSC(8), .OPEN_OSC(6), .NRES_CYC(20)) i_dut (
		.clk_i(clk), .reset_n_i(rst_n), .pins_i({trig_n, en, tx, rx, uv, slp}),
		.timing_resistor_i(rres), .txd_data_i(txd), .nres_n_o(nres),
		.bus_tx_o(tx_o), .bus_tx_en_o(tx_en), .mode_o(mode), .wd_state_o(st));
	task automatic cmp(input string n, input logic [1:0] e, input logic [1:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_v(input string n, input logic [1:0] e, input bit md);
		int i;
		@(negedge clk);
		for (i = 0; i < 300 && (md ? mode : st) !== e; i++) @(negedge clk);
		cmp(n, e, md ? mode : st);
	endtask
	task automatic t_power;
		tick(10);
		cmp("nres", 2'h0, nres);
		cmp("mode", WWD_MODE_FAILSAFE, mode);
		wait_v("state", WWD_ST_LEAD, 1'b0);
		tick(2);
		cmp("nres", 2'h1, nres);
		cmp("bus_tx", {1'b0, ~txd}, tx_o);
		$display("test power done");
	endtask
	task automatic t_window;
		i_host.fire(2);
		tick(2);
		cmp("state", WWD_ST_LEAD, st);
		i_host.fire(3);
		wait_v("state", WWD_ST_CLOSED, 1'b0);
		wait_v("state", WWD_ST_OPEN, 1'b0);
		i_host.fire(3);
		wait_v("state", WWD_ST_CLOSED, 1'b0);
		cmp("nres", 2'h1, nres);
		i_host.fire(3);
		tick(10);
		cmp("nres", 2'h0, nres);
		wait_v("state", WWD_ST_LEAD, 1'b0);
		$display("test window done");
	endtask
	task automatic t_expire;
		wait_v("state", WWD_ST_RESET, 1'b0);
		cmp("nres", 2'h0, nres);
		wait_v("state", WWD_ST_LEAD, 1'b0);
		i_host.fire(3);
		wait_v("state", WWD_ST_OPEN, 1'b0);
		wait_v("state", WWD_ST_RESET, 1'b0);
		cmp("nres", 2'h0, nres);
		$display("test expire done");
	endtask
	// Kind 0 silent, 1 sleep, 2 silent ended by undervoltage
	task automatic t_quiet(input int k);
		wwd_state_t s0;
		wait_v("mode", WWD_MODE_NORMAL, 1'b1);
		@(posedge clk);
		slp <= (k == 1);
		en <= (k == 1);
		tick(8);
		cmp("mode", k == 1 ? WWD_MODE_SLEEP : WWD_MODE_SILENT, mode);
		cmp("tx_en", 2'h0, tx_en);
		s0 = st;
		tick(80);
		cmp("state", s0, st);
		cmp("nres", 2'h1, nres);
		@(posedge clk);
		uv <= (k == 2);
		rx <= (k == 2);
		slp <= 1'b0;
		tick(8);
		cmp("mode", k == 2 ? WWD_MODE_FAILSAFE : WWD_MODE_NORMAL, mode);
		cmp("state", k == 2 ? WWD_ST_RESET : WWD_ST_LEAD, st);
		cmp("nres", {1'b0, k != 2}, nres);
		@(posedge clk);
		rx <= 1'b1;
		uv <= 1'b0;
		en <= 1'b1;
		$display("test quiet %0d done", k);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_power;
		t_window;
		t_expire;
		t_quiet(0);
		t_quiet(1);
		t_quiet(2);
		report_and_stop;
	end
	// About 500 cycles expected; 20000 means a hang
	initial begin
		#2000000;
		n_errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
